// ### hw/fe_params.svh
`ifndef FE_PARAMS_SVH
`define FE_PARAMS_SVH

// Link word and header geometry
`define FE_WORD_W       20
`define FE_HDR_BYTES    64
`define FE_HDR_AW       6
`define FE_PED_WORD     16
`define FE_PORTS        3

// Command codes carried in the low nibble of a command word
`define FE_CMD_SOH      4'h1
`define FE_CMD_SOD      4'h2
`define FE_CMD_EOE      4'h3
`define FE_CMD_ABORT    4'h4

// Fixed local address map
`define FE_ADDR_SDRAM   32'h0000_0000
`define FE_ADDR_HDR     32'h0080_0000
`define FE_ADDR_REGS    32'h0080_8000
`define FE_SPAN_SDRAM   32'h0080_0000
`define FE_SPAN_HDR     32'h0000_0100
`define FE_SPAN_REGS    32'h0000_0100

// Reset values of software settings
`define FE_MODE_RST     1'b0
`define FE_BUSY_EN_RST  1'b0

`endif

// ### hw/fe_pkg.sv
package fe_pkg;

  // Front-end event sequence
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_WAIT_SOD,
    ST_DATA,
    ST_DONE
  } fe_state_e;

  // Local address regions
  typedef enum logic [1:0] {
    REG_NONE,
    REG_SDRAM,
    REG_HDR,
    REG_CTRL
  } region_e;

  typedef struct packed {
    // Pin synchronisers
    logic [19:0]      data_s1;
    logic [19:0]      data_s2;
    logic             cmd_s1;
    logic             cmd_s2;
    logic             vld_s1;
    logic             vld_s2;
    logic             rdy_s1;
    logic             rdy_s2;
    logic             err_s1;
    logic             err_s2;
    // Sequence
    fe_state_e        state;
    logic [6:0]       hdr_cnt;
    logic [1:0]       next_port;
    // Header write port
    logic             hw_en;
    logic [5:0]       hw_addr;
    logic [7:0]       hw_data;
    // Two-entry buffer
    logic [1:0][19:0] buf_data;
    logic [1:0][1:0]  buf_port;
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       buf_cnt;
    // Settings and flags
    logic             mode_silicon;
    logic             busy_en;
    logic [2:0]       hold;
    logic [2:0]       pause;
    logic             busy;
    logic             busy_pin;
    logic             overrun;
    logic             size_err;
    logic             overflow;
    // Pulses
    logic             fe_clear;
    logic             eoe;
    logic             abort;
    logic             fault;
    logic             ped;
  } ctl_s;

endpackage

// ### hw/frontend_busy_header_control.sv
// Function
// - Forward each 20-bit data word after start-of-data that finds buffer room to one of three ports with own strobe
// - Strip the 64-byte header and write it into header memory
// - All front-end logic runs synchronously on one clock
// - Check header size; pedestal strobe on 16th header word in tracker mode
// - Drive end-of-event, fault and abort signals to the mezzanines
// - Expose status and error bits for link and front-end state
// - BUSY output driven only while the software enable is set
// - Set BUSY on header start, link error, link down or any hold or pause flag
// - Release BUSY when link fine, no hold or pause flags, and clear or abort seen
// - Start-of-data command sets all three hold flags
// - Clearing the last hold flag sends one clear pulse to front-end
// - One software set/clear pause flag per mezzanine
// - Header start while busy raises a busy-overrun fault
// - Fixed decode: general memory, header memory, control registers
// - Header bytes written sequentially become readable at random port
// - Header byte n sits in low byte of word at address 4n
// - Reset disables BUSY, drift mode, clears flags and front-end
// - Write clears only that port's hold flag; read shows all three
`include "fe_params.svh"

module frontend_busy_header_control #(
  parameter int HDR_BYTES = `FE_HDR_BYTES,
  parameter int PED_WORD  = `FE_PED_WORD
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Deserializer pins
  input  wire logic [19:0] link_data,
  input  wire logic        link_command_word,
  input  wire logic        link_valid,
  input  wire logic        link_ready,
  input  wire logic        link_error,
  output logic             link_accept,
  // Mezzanine local bus
  output logic [19:0]      mz_data,
  output logic [2:0]       mz_strobe,
  input  wire logic [2:0]  mz_ready,
  output logic             mz_end_event,
  output logic             mz_fault,
  output logic             mz_abort,
  output logic             pedestal_strobe,
  output logic             frontend_clear_pulse,
  // Software settings and flags
  input  wire logic        mode_wr,
  input  wire logic        silicon_tracker_mode,
  input  wire logic        busy_en_wr,
  input  wire logic        busy_en_val,
  input  wire logic [2:0]  hold_clear_wr,
  input  wire logic [2:0]  pause_set_wr,
  input  wire logic [2:0]  pause_clear_wr,
  input  wire logic        frontend_clear_control,
  input  wire logic        error_clear,
  output logic [2:0]       event_hold_flag,
  output logic [2:0]       pause_request_flag,
  output logic             drift_chamber_mode,
  output logic [7:0]       fe_status,
  output logic [7:0]       fe_errors,
  // Crate busy
  output logic             busy_out,
  // Local address decode and header read
  input  wire logic [31:0] loc_addr,
  input  wire logic        loc_rd,
  output logic             sel_sdram,
  output logic             sel_header,
  output logic             sel_regs,
  output logic [31:0]      hdr_rdata,
  output logic             hdr_rvalid
);

  fe_pkg::ctl_s q;
  fe_pkg::ctl_s d;
  logic         out_valid;
  logic         in_ready;
  logic         pop;

  // Region decode, shared by selects and header read
  function automatic fe_pkg::region_e decode(input logic [31:0] a);
    if (a - `FE_ADDR_HDR < `FE_SPAN_HDR) begin
      decode = fe_pkg::REG_HDR;
    end else if (a - `FE_ADDR_REGS < `FE_SPAN_REGS) begin
      decode = fe_pkg::REG_CTRL;
    end else if (a - `FE_ADDR_SDRAM < `FE_SPAN_SDRAM) begin
      decode = fe_pkg::REG_SDRAM;
    end else begin
      decode = fe_pkg::REG_NONE;
    end
  endfunction

  // Buffer handshake; head word goes to the port stored with it
  assign out_valid = q.buf_cnt != 2'h0;
  assign in_ready  = q.buf_cnt != 2'h2;
  assign pop       = out_valid && mz_ready[q.buf_port[q.rd_ptr]];

  // Next-state logic for the whole block
  always_comb begin
    logic       word_v;
    logic       is_cmd;
    logic       soh;
    logic       sod;
    logic       eoe;
    logic       abrt;
    logic       push;
    logic       hold_done;
    logic       set_c;
    logic       rel_c;
    word_v    = 1'b0;
    is_cmd    = 1'b0;
    soh       = 1'b0;
    sod       = 1'b0;
    eoe       = 1'b0;
    abrt      = 1'b0;
    push      = 1'b0;
    hold_done = 1'b0;
    set_c     = 1'b0;
    rel_c     = 1'b0;
    d         = q;

    // Two-stage synchronisers on every deserializer pin
    d.data_s1 = link_data;
    d.data_s2 = q.data_s1;
    d.cmd_s1  = link_command_word;
    d.cmd_s2  = q.cmd_s1;
    d.vld_s1  = link_valid;
    d.vld_s2  = q.vld_s1;
    d.rdy_s1  = link_ready;
    d.rdy_s2  = q.rdy_s1;
    d.err_s1  = link_error;
    d.err_s2  = q.err_s1;

    // Pulses last one cycle
    d.hw_en    = 1'b0;
    d.fe_clear = 1'b0;
    d.eoe      = 1'b0;
    d.abort    = 1'b0;
    d.fault    = 1'b0;
    d.ped      = 1'b0;

    // Sticky errors clear first, so an error raised below in the same cycle wins
    if (error_clear) begin
      d.overrun  = 1'b0;
      d.size_err = 1'b0;
      d.overflow = 1'b0;
    end

    // Decode the synchronised word
    word_v = q.vld_s2 && !q.cmd_s2;
    is_cmd = q.vld_s2 && q.cmd_s2;
    soh    = is_cmd && q.data_s2[3:0] == `FE_CMD_SOH;
    sod    = is_cmd && q.data_s2[3:0] == `FE_CMD_SOD;
    eoe    = is_cmd && q.data_s2[3:0] == `FE_CMD_EOE;
    abrt   = is_cmd && q.data_s2[3:0] == `FE_CMD_ABORT;

    // Software settings
    if (mode_wr) begin
      d.mode_silicon = silicon_tracker_mode;
    end
    if (busy_en_wr) begin
      d.busy_en = busy_en_val;
    end
    d.pause = (q.pause & ~pause_clear_wr) | pause_set_wr;

    // Hold flags: start-of-data set wins over a same-cycle clear
    d.hold = sod ? 3'h7 : (q.hold & ~hold_clear_wr);
    hold_done  = (q.hold != 3'h0) && (d.hold == 3'h0);
    d.fe_clear = hold_done || frontend_clear_control;

    // Front-end sequence
    case (q.state)
      fe_pkg::ST_IDLE: begin
        if (soh) begin
          d.state   = fe_pkg::ST_HDR;
          d.hdr_cnt = 7'h00;
        end
      end
      fe_pkg::ST_HDR: begin
        if (word_v) begin
          d.hw_en   = 1'b1;
          d.hw_addr = q.hdr_cnt[5:0];
          d.hw_data = q.data_s2[7:0];
          d.hdr_cnt = q.hdr_cnt + 7'h01;
          if (q.mode_silicon && q.hdr_cnt == 7'(PED_WORD - 1)) begin
            d.ped = 1'b1;
          end
          if (q.hdr_cnt == 7'(HDR_BYTES - 1)) begin
            d.state = fe_pkg::ST_WAIT_SOD;
          end
        end else if (is_cmd && !abrt) begin
          // Header cut short
          d.size_err = 1'b1;
          d.fault    = 1'b1;
          d.state    = fe_pkg::ST_DONE;
        end
      end
      fe_pkg::ST_WAIT_SOD: begin
        if (sod) begin
          d.state     = fe_pkg::ST_DATA;
          d.next_port = 2'h0;
        end else if (word_v) begin
          // Header longer than expected
          d.size_err = 1'b1;
          d.fault    = 1'b1;
        end
      end
      fe_pkg::ST_DATA: begin
        if (word_v) begin
          push = in_ready;
          if (!in_ready) begin
            // Link cannot be stalled, so a full buffer loses the word
            d.overflow = 1'b1;
            d.fault    = 1'b1;
          end
        end else if (eoe) begin
          d.eoe   = 1'b1;
          d.state = fe_pkg::ST_DONE;
        end
      end
      fe_pkg::ST_DONE: begin
        if (soh) begin
          d.state   = fe_pkg::ST_HDR;
          d.hdr_cnt = 7'h00;
        end
      end
      default: begin
        d.state = fe_pkg::ST_IDLE;
      end
    endcase

    // Abort and clear return the sequence to idle
    if (abrt) begin
      d.abort = 1'b1;
      d.state = fe_pkg::ST_IDLE;
    end
    if (q.fe_clear) begin
      d.state = fe_pkg::ST_IDLE;
    end

    // Two-entry buffer, round-robin port choice
    if (push) begin
      d.buf_data[q.wr_ptr] = q.data_s2;
      d.buf_port[q.wr_ptr] = q.next_port;
      d.wr_ptr             = ~q.wr_ptr;
      d.next_port          = (q.next_port == 2'h2) ? 2'h0 : q.next_port + 2'h1;
    end
    if (pop) begin
      d.rd_ptr = ~q.rd_ptr;
    end
    d.buf_cnt = q.buf_cnt + {1'b0, push} - {1'b0, pop};

    // Busy overrun, checked against the registered busy
    if (soh && q.busy) begin
      d.overrun = 1'b1;
      d.fault   = 1'b1;
    end
    // Busy set and release
    set_c = soh || q.err_s2 || !q.rdy_s2 || (q.pause != 3'h0) || (q.hold != 3'h0);
    rel_c = q.rdy_s2 && !q.err_s2 && (q.pause == 3'h0) && (q.hold == 3'h0)
            && (q.fe_clear || abrt);
    if (set_c) begin
      d.busy = 1'b1;
    end else if (rel_c) begin
      d.busy = 1'b0;
    end
    d.busy_pin = d.busy_en && d.busy;
  end

  // Single register stage for all state, on the one system clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q              <= '0;
      q.state        <= fe_pkg::ST_IDLE;
      q.mode_silicon <= `FE_MODE_RST;
      q.busy_en      <= `FE_BUSY_EN_RST;
      q.busy         <= 1'b1;
      q.fe_clear     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Header storage
  header_mem #(
    .DEPTH (HDR_BYTES),
    .AW    (`FE_HDR_AW)
  ) header_mem_inst (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .wr_en    (q.hw_en),
    .wr_addr  (q.hw_addr),
    .wr_data  (q.hw_data),
    .rd_en    (loc_rd && decode(loc_addr) == fe_pkg::REG_HDR),
    .rd_addr  (loc_addr[7:2]),
    .rd_word  (hdr_rdata),
    .rd_valid (hdr_rvalid)
  );

  // Decoder selects
  assign sel_sdram  = decode(loc_addr) == fe_pkg::REG_SDRAM;
  assign sel_header = decode(loc_addr) == fe_pkg::REG_HDR;
  assign sel_regs   = decode(loc_addr) == fe_pkg::REG_CTRL;

  // Mezzanine side; strobe is the handshake, data comes from the buffer flops
  assign mz_data     = q.buf_data[q.rd_ptr];
  assign link_accept = in_ready;
  generate
    for (genvar i = 0; i < `FE_PORTS; i++) begin : g_strobe
      assign mz_strobe[i] = pop && q.buf_port[q.rd_ptr] == 2'(i);
    end
  endgenerate

  // Event controls and flags
  assign mz_end_event         = q.eoe;
  assign mz_fault             = q.fault;
  assign mz_abort             = q.abort;
  assign pedestal_strobe      = q.ped;
  assign frontend_clear_pulse = q.fe_clear;
  assign event_hold_flag      = q.hold;
  assign pause_request_flag   = q.pause;
  assign drift_chamber_mode   = !q.mode_silicon;
  assign busy_out             = q.busy_pin;

  // Status and error views
  assign fe_status = {q.state, q.busy, q.rdy_s2, q.err_s2, out_valid, q.busy_en};
  assign fe_errors = {5'h00, q.overflow, q.size_err, q.overrun};

endmodule

// ### hw/header_mem.sv
`include "fe_params.svh"

module header_mem #(
  parameter int DEPTH = `FE_HDR_BYTES,
  parameter int AW    = `FE_HDR_AW
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // Sequential write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Random read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic [31:0]        rd_word,
  output logic               rd_valid
);

  logic [7:0] mem [DEPTH];

  // Storage array has no reset; contents are defined once a header is written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Byte sits in the low lane, upper lanes read as zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_word  <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_word <= {24'h00_0000, mem[rd_addr]};
      end
    end
  end

endmodule

// ### tb/fe_ctl_chk.sv
module fe_ctl_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Watched ports
  input wire logic [2:0]  mz_strobe,
  input wire logic [2:0]  mz_ready,
  input wire logic        pedestal_strobe,
  input wire logic        frontend_clear_pulse,
  input wire logic [2:0]  pause_set_wr,
  input wire logic [2:0]  hold_clear_wr,
  input wire logic [2:0]  event_hold_flag,
  input wire logic [2:0]  pause_request_flag,
  input wire logic        drift_chamber_mode,
  input wire logic [7:0]  fe_status,
  input wire logic [7:0]  fe_errors,
  input wire logic        busy_out,
  input wire logic [31:0] loc_addr,
  input wire logic        loc_rd,
  input wire logic        sel_sdram,
  input wire logic        sel_header,
  input wire logic        sel_regs,
  input wire logic [31:0] hdr_rdata,
  input wire logic        hdr_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Relations between the block's outputs and their causes
  a_strobe_one_port: assert property ($onehot0(mz_strobe) && (mz_strobe & ~mz_ready) == 3'h0)
    else $error("strobe not one-hot or without ready");
  a_ped_tracker: assert property (pedestal_strobe |-> !drift_chamber_mode)
    else $error("pedestal strobe in drift mode");
  a_busy_gated: assert property (!fe_status[0] && !$past(fe_status[0]) |-> !busy_out)
    else $error("busy out while disabled");
  a_link_down_busy: assert property (!fe_status[3] |-> ##[1:2] fe_status[4])
    else $error("no busy while link down");
  a_hold_all_set: assert property ($rose(|event_hold_flag) |-> event_hold_flag == 3'h7)
    else $error("hold flags not set together");
  a_hold_own_clear: assert property (
    ($past(event_hold_flag) & ~event_hold_flag & ~$past(hold_clear_wr)) == 3'h0)
    else $error("hold flag cleared without its write");
  a_last_hold_pulse: assert property ($fell(|event_hold_flag) |-> ##[0:1] frontend_clear_pulse)
    else $error("no clear pulse after last hold");
  a_pause_set_wr: assert property (
    |pause_set_wr |=> (pause_request_flag & $past(pause_set_wr)) == $past(pause_set_wr))
    else $error("pause flag not set");
  a_overrun_busy: assert property ($rose(fe_errors[0]) |-> $past(fe_status[4]))
    else $error("overrun without busy");
  a_decode_map: assert property (
    sel_sdram == (loc_addr < 32'h0080_0000) && sel_header == (loc_addr[31:8] == 24'h008000)
    && sel_regs == (loc_addr[31:8] == 24'h008080))
    else $error("local decode wrong");
  a_hdr_low_byte: assert property (loc_rd && sel_header |=> hdr_rvalid && hdr_rdata[31:8] == 24'h0)
    else $error("header read answer wrong");

  // Main scenarios reached
  cover property ($rose(busy_out));
  cover property (event_hold_flag == 3'h7);
  cover property ($rose(fe_errors[0]));
endmodule

bind frontend_busy_header_control fe_ctl_chk fe_ctl_chk_inst (
  .clk_sys(clk_sys), .reset(reset), .mz_strobe(mz_strobe), .mz_ready(mz_ready),
  .pedestal_strobe(pedestal_strobe), .frontend_clear_pulse(frontend_clear_pulse),
  .pause_set_wr(pause_set_wr), .hold_clear_wr(hold_clear_wr), .event_hold_flag(event_hold_flag),
  .pause_request_flag(pause_request_flag), .drift_chamber_mode(drift_chamber_mode),
  .fe_status(fe_status), .fe_errors(fe_errors), .busy_out(busy_out), .loc_addr(loc_addr), .loc_rd(loc_rd),
  .sel_sdram(sel_sdram), .sel_header(sel_header), .sel_regs(sel_regs), .hdr_rdata(hdr_rdata),
  .hdr_rvalid(hdr_rvalid)
);

// ### tb/fe_mz_model.sv
module fe_mz_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Local bus from the block
  input  wire logic [19:0] mz_data,
  input  wire logic [2:0]  mz_strobe,
  output logic [2:0]       mz_ready,
  // Storage full on all boards
  input  wire logic        stall
);
  timeunit 1ns;
  timeprecision 1ps;
  int          got [3];
  logic [19:0] last_q;

  // No room means no port ready; words wait in the block
  assign mz_ready = stall ? 3'h0 : 3'h7;

  // A strobe marks the word taken by that board
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      got = '{0, 0, 0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (mz_strobe[i] === 1'b1) begin
          got[i]++;
          last_q <= mz_data;
        end
      end
    end
  end
endmodule

// ### tb/frontend_busy_header_control_test.sv
module frontend_busy_header_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Driven inputs, plus mz_ready and the vector design outputs
  logic        clk_sys, reset, link_command_word, link_valid, link_ready, link_error, stall;
  logic        mode_wr, silicon_tracker_mode, busy_en_wr, busy_en_val, frontend_clear_control, error_clear, loc_rd;
  logic [2:0]  hold_clear_wr, pause_set_wr, pause_clear_wr, mz_strobe, mz_ready, event_hold_flag, pause_request_flag;
  logic [19:0] link_data, mz_data;
  logic [31:0] loc_addr, hdr_rdata;
  logic [7:0]  fe_status, fe_errors;
  // Design outputs
  logic        link_accept, mz_end_event, mz_fault, mz_abort, pedestal_strobe, frontend_clear_pulse;
  logic        drift_chamber_mode, busy_out, sel_sdram, sel_header, sel_regs, hdr_rvalid;
  int          err_count, cmp_count, n_ped, n_eoe, n_abt, n_flt, n_clr;

  frontend_busy_header_control frontend_busy_header_control_inst (
    .clk_sys(clk_sys), .reset(reset), .link_data(link_data), .link_command_word(link_command_word),
    .link_valid(link_valid), .link_ready(link_ready), .link_error(link_error), .link_accept(link_accept),
    .mz_data(mz_data), .mz_strobe(mz_strobe), .mz_ready(mz_ready), .mz_end_event(mz_end_event),
    .mz_fault(mz_fault), .mz_abort(mz_abort), .pedestal_strobe(pedestal_strobe),
    .frontend_clear_pulse(frontend_clear_pulse), .mode_wr(mode_wr), .silicon_tracker_mode(silicon_tracker_mode),
    .busy_en_wr(busy_en_wr), .busy_en_val(busy_en_val), .hold_clear_wr(hold_clear_wr),
    .pause_set_wr(pause_set_wr), .pause_clear_wr(pause_clear_wr), .frontend_clear_control(frontend_clear_control),
    .error_clear(error_clear), .event_hold_flag(event_hold_flag), .pause_request_flag(pause_request_flag),
    .drift_chamber_mode(drift_chamber_mode), .fe_status(fe_status), .fe_errors(fe_errors), .busy_out(busy_out),
    .loc_addr(loc_addr), .loc_rd(loc_rd), .sel_sdram(sel_sdram), .sel_header(sel_header), .sel_regs(sel_regs),
    .hdr_rdata(hdr_rdata), .hdr_rvalid(hdr_rvalid));

  fe_mz_model fe_mz_model_inst (.clk_sys(clk_sys), .reset(reset), .mz_data(mz_data), .mz_strobe(mz_strobe),
    .mz_ready(mz_ready), .stall(stall));

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // Pulse counters; the clear pulse is high during reset, so skip it
  always @(posedge clk_sys) begin
    if (!reset) begin
      n_ped += (pedestal_strobe === 1'b1);
      n_eoe += (mz_end_event === 1'b1);
      n_abt += (mz_abort === 1'b1);
      n_flt += (mz_fault === 1'b1);
      n_clr += (frontend_clear_pulse === 1'b1);
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One link word a cycle; valid stays up for back-to-back words
  task automatic word(logic c, logic [19:0] d);
    @(posedge clk_sys);
    link_valid <= 1'b1;
    link_command_word <= c;
    link_data <= d;
  endtask

  // Released link shows a changed pattern, not the last word
  task automatic idle();
    @(posedge clk_sys);
    link_valid <= 1'b0;
    link_data <= ~link_data;
  endtask

  // Front-end clear from software, then busy must drop
  task automatic fe_clear();
    @(posedge clk_sys);
    frontend_clear_control <= 1'b1;
    @(posedge clk_sys);
    frontend_clear_control <= 1'b0;
    tick(3);
    #1;
    chk("busy_out", 0, busy_out);
  endtask

  task automatic t_reset();
    tick(1);
    #1;
    chk("busy_out", 0, busy_out);
    chk("drift_mode", 1, drift_chamber_mode);
    chk("flags", 0, {event_hold_flag, pause_request_flag, fe_status[0]});
    tick(4);
    @(posedge clk_sys);
    mode_wr <= 1'b1;
    silicon_tracker_mode <= 1'b1;
    busy_en_wr <= 1'b1;
    busy_en_val <= 1'b1;
    @(posedge clk_sys);
    mode_wr <= 1'b0;
    busy_en_wr <= 1'b0;
    fe_clear();
    $display("test reset done");
  endtask

  // Header, stalled data, end of event, header readback
  task automatic t_event();
    word(1'b1, 20'h00001);
    for (int n = 0; n < 64; n++) word(1'b0, {12'h0, 8'(n)});
    idle();
    tick(4);
    #1;
    chk("busy_out", 1, busy_out);
    chk("hdr_fwd", 0, fe_mz_model_inst.got[0]);
    chk("pedestal", 1, n_ped);
    @(posedge clk_sys);
    stall <= 1'b1;
    word(1'b1, 20'h00002);
    word(1'b0, 20'h00101);
    word(1'b0, 20'h00102);
    idle();
    tick(4);
    #1;
    chk("hold", 7, event_hold_flag);
    chk("accept", 0, link_accept);
    @(posedge clk_sys);
    stall <= 1'b0;
    for (int k = 3; k < 7; k++) word(1'b0, 20'h00100 + 20'(k));
    word(1'b1, 20'h00003);
    idle();
    tick(6);
    #1;
    for (int p = 0; p < 3; p++) chk("port_words", 2, fe_mz_model_inst.got[p]);
    chk("last_word", 20'h00106, fe_mz_model_inst.last_q);
    chk("end_event", 1, n_eoe);
    chk("errors", 0, fe_errors);
    for (int n = 0; n < 64; n++) begin
      @(posedge clk_sys);
      loc_addr <= 32'h0080_0000 + 32'(4 * n);
      loc_rd <= 1'b1;
      @(posedge clk_sys);
      loc_rd <= 1'b0;
      // Answer stands for the one cycle after the read edge
      #1;
      chk("hdr_rvalid", 1, hdr_rvalid);
      chk("hdr_word", {24'h0, 8'(n)}, hdr_rdata);
      chk("hdr_byte", 32'(n), hdr_rdata & 32'h0000_00ff);
    end
    $display("test event done");
  endtask

  // Header start while busy, abort, then boards free their holds
  task automatic t_overrun();
    int c0;
    word(1'b1, 20'h00001);
    idle();
    tick(5);
    #1;
    chk("overrun", 1, fe_errors[0]);
    chk("fault", 1, n_flt);
    // End command inside the header cuts it short
    word(1'b1, 20'h00003);
    idle();
    tick(5);
    #1;
    chk("size_err", 1, fe_errors[1]);
    chk("fault", 2, n_flt);
    word(1'b1, 20'h00004);
    idle();
    tick(5);
    #1;
    chk("abort", 1, n_abt);
    chk("state", 0, fe_status[7:5]);
    @(posedge clk_sys);
    error_clear <= 1'b1;
    @(posedge clk_sys);
    error_clear <= 1'b0;
    tick(2);
    #1;
    chk("errors", 0, fe_errors);
    c0 = n_clr;
    for (int p = 0; p < 3; p++) begin
      @(posedge clk_sys);
      hold_clear_wr <= 3'(3'h1 << p);
      @(posedge clk_sys);
      hold_clear_wr <= 3'h0;
      tick(2);
      #1;
      chk("hold", 3'(3'h7 << (p + 1)), event_hold_flag);
    end
    tick(2);
    #1;
    chk("clear_pulse", c0 + 1, n_clr);
    chk("busy_out", 0, busy_out);
    $display("test overrun done");
  endtask

  // Pause flag, enable gating, link error
  task automatic t_pause();
    @(posedge clk_sys);
    pause_set_wr <= 3'h2;
    @(posedge clk_sys);
    pause_set_wr <= 3'h0;
    tick(2);
    #1;
    chk("pause", 2, pause_request_flag);
    chk("busy_out", 1, busy_out);
    @(posedge clk_sys);
    busy_en_wr <= 1'b1;
    busy_en_val <= 1'b0;
    @(posedge clk_sys);
    busy_en_wr <= 1'b0;
    tick(2);
    #1;
    chk("busy_out", 0, busy_out);
    @(posedge clk_sys);
    busy_en_wr <= 1'b1;
    busy_en_val <= 1'b1;
    pause_clear_wr <= 3'h2;
    @(posedge clk_sys);
    busy_en_wr <= 1'b0;
    pause_clear_wr <= 3'h0;
    tick(3);
    #1;
    chk("pause", 0, pause_request_flag);
    chk("busy_out", 1, busy_out);
    fe_clear();
    @(posedge clk_sys);
    link_error <= 1'b1;
    tick(5);
    #1;
    chk("busy_out", 1, busy_out);
    @(posedge clk_sys);
    link_error <= 1'b0;
    tick(4);
    fe_clear();
    $display("test pause done");
  endtask

  // Fixed map, one unmapped place between regions
  task automatic t_decode();
    logic [31:0] a [4] = '{32'h0000_0000, 32'h0080_00fc, 32'h0080_8000, 32'h0080_4000};
    logic [2:0]  e [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      loc_addr <= a[i];
      tick(1);
      #1;
      chk("decode", e[i], {sel_sdram, sel_header, sel_regs});
    end
    $display("test decode done");
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Idle levels at time zero, link up, then the scenarios
  initial begin
    clk_sys = 1'b0;
    {reset, link_ready} = 2'h3;
    {link_command_word, link_valid, link_error, stall, mode_wr, silicon_tracker_mode} = 6'h0;
    {busy_en_wr, busy_en_val, frontend_clear_control, error_clear, loc_rd} = 5'h0;
    {link_data, hold_clear_wr, pause_set_wr, pause_clear_wr, loc_addr} = 61'h0;
    tick(10);
    reset <= 1'b0;
    t_reset();
    t_event();
    t_overrun();
    t_pause();
    t_decode();
    results();
  end

  // Hang guard
  initial begin
    tick(40000);
    err_count++;
    results();
  end
endmodule
